// File: pulse_meter.sv
// Meter on the pulse pin: width of the last high pulse in cycles
`timescale 1ns/10ps
`default_nettype none
module pulse_meter (
    input  wire logic        clock,
    input  wire logic        pin,
    output var  logic [12:0] width
);
    logic [12:0] run = 13'h0000;
    always @(posedge clock) begin
        run <= pin ? run + 13'h0001 : 13'h0000;
        if (!pin && run != 13'h0000) begin
            width <= run;
        end
    end
endmodule // pulse_meter
`default_nettype wire

// File: rssi_pwm_checker.sv
// Port assertions of the signal-strength pulse-width indicator
`timescale 1ns/10ps
`default_nettype none
module rssi_pwm_checker (
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic       hold_time_load,
    input wire logic [7:0] hold_time_value,
    input wire logic       pin_function_load,
    input wire logic [1:0] pin_function_value,
    input wire logic       first_pulse_output,
    input wire logic [7:0] strength_pulse_hold_time,
    input wire logic [1:0] first_pulse_pin_function,
    input wire logic [8:0] shown_duty_steps,
    input wire logic       indicator_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    AST_ACTIVE: assert property (indicator_active == (shown_duty_steps != 0))
        else $error("active flag wrong");
    AST_DARK_LOW: assert property (shown_duty_steps == 9'h000 |-> !first_pulse_output)
        else $error("pin high at zero duty");
    AST_FULL_HIGH: assert property (shown_duty_steps == 9'h1bd |-> first_pulse_output)
        else $error("pin low at full duty");
    AST_START_DARK: assert property ($rose(rst_b) |-> shown_duty_steps == 9'h000)
        else $error("duty not zero after reset");
    AST_HOLD_LOAD: assert property (hold_time_load
        |=> strength_pulse_hold_time == $past(hold_time_value)) else $error("hold load");
    AST_FUNC_LOAD: assert property (pin_function_load && pin_function_value != 2'h3
        |=> first_pulse_pin_function == $past(pin_function_value)) else $error("func load");
    AST_FUNC_KEEP: assert property (pin_function_load && pin_function_value == 2'h3
        |=> $stable(first_pulse_pin_function)) else $error("func code 3 taken");
    AST_DUTY_HOLD: assert property ($changed(shown_duty_steps)
        |=> $stable(shown_duty_steps)[*8]) else $error("duty changed mid period");
endmodule // rssi_pwm_checker
bind rssi_pwm_indicator rssi_pwm_checker checker_i (
    .clock(clock), .rst_b(rst_b), .hold_time_load(hold_time_load),
    .hold_time_value(hold_time_value), .pin_function_load(pin_function_load),
    .pin_function_value(pin_function_value), .indicator_active(indicator_active),
    .first_pulse_output(first_pulse_output), .shown_duty_steps(shown_duty_steps),
    .strength_pulse_hold_time(strength_pulse_hold_time),
    .first_pulse_pin_function(first_pulse_pin_function));
`default_nettype wire

// File: rssi_pwm_indicator.v
// Signal-strength pulse-width indicator for the first pulse pin
//
// Operation
// R1: Pulse period fixed at 64 us.
// R2: 445 duty steps of 144 ns each.
// R3: Above sensitivity duty 24 to 100 percent.
// R4: Zero percent duty means indicator inactive.
// R5: At or below sensitivity duty 1 to 24 percent.
// R6: 10/20/30 dB give 41/58/75 percent.
// R7: Nonzero hold setting times display in 100 ms.
// R8: Hold expiry forces zero duty until packet.
// R9: Zero duty from reset until first packet.
// R10: Setting 0xFF never times out.
// R11: Hold setting 0 to 0xFF, resets 0x28.
// R12: Pin function off, strength or pass-through.
// R13: Packet reloads timer, interpolates, saturates at full.
// R14: New duty applied only at period start.
`timescale 1ns/10ps
`default_nettype none
`include "rssi_pwm_indicator_defines.vh"

module rssi_pwm_indicator #(
    parameter PERIOD_CYCLES = `PERIOD_NS * `CLOCK_MHZ / 1000,
    parameter PERIOD_W      = 13,
    parameter TENTH_CYCLES  = `HOLD_UNIT_MS * 1000 * `CLOCK_MHZ,
    parameter TENTH_W       = 24
) (
    input  wire       clock,
    input  wire       rst_b,
    input  wire       packet_received,
    input  wire [7:0] packet_strength_db,
    input  wire       hold_time_load,
    input  wire [7:0] hold_time_value,
    input  wire       pin_function_load,
    input  wire [1:0] pin_function_value,
    input  wire [8:0] passed_duty_steps,
    output reg        first_pulse_output,
    output reg  [7:0] strength_pulse_hold_time,
    output reg  [1:0] first_pulse_pin_function,
    output reg  [8:0] shown_duty_steps,
    output wire       indicator_active
);

    localparam integer STEP_CYCLES =
        (`STEP_NS * `CLOCK_MHZ + 999) / 1000;
    localparam integer PERIOD_LAST_I = PERIOD_CYCLES - 1;
    localparam integer TENTH_LAST_I  = TENTH_CYCLES - 1;
    localparam integer STEP_LAST_I   = STEP_CYCLES - 1;
    // Counter end points cut to their counter widths
    localparam [PERIOD_W-1:0] PERIOD_LAST = PERIOD_LAST_I[PERIOD_W-1:0];
    localparam [TENTH_W-1:0]  TENTH_LAST  = TENTH_LAST_I[TENTH_W-1:0];
    localparam [4:0]          STEP_LAST   = STEP_LAST_I[4:0];
    localparam [8:0]          STEP_TOP    = `STEP_COUNT - 9'h001;

    // Display states, one-hot
    localparam [2:0] ST_DARK   = 3'h1;
    localparam [2:0] ST_HOLD   = 3'h2;
    localparam [2:0] ST_STEADY = 3'h4;

    // Signed dB above sensitivity to duty steps
    function [8:0] strength_to_steps;
        input [7:0] db;
        reg signed [23:0] prod;
        reg signed [23:0] val;
        begin
            prod = $signed({{16{db[7]}}, db}) * `DUTY_SLOPE;
            val  = `DUTY_AT_SENS + (prod >>> `DUTY_SLOPE_SHIFT);
            if (val > `DUTY_FULL) begin
                val = `DUTY_FULL;
            end else if (val < `DUTY_MIN) begin
                val = `DUTY_MIN;
            end
            strength_to_steps = val[8:0];
        end
    endfunction

    // Display state that a packet starts, from the hold setting
    function [2:0] state_on_packet;
        input [7:0] hold;
        begin
            if (hold == `HOLD_FOREVER) begin
                state_on_packet = ST_STEADY; // R10
            end else if (hold == `HOLD_NONE) begin
                state_on_packet = ST_DARK;
            end else begin
                state_on_packet = ST_HOLD; // R7
            end
        end
    endfunction

    // Pass-through duty limited to full scale
    function [8:0] clamp_duty;
        input [8:0] steps;
        begin
            if (steps > `STEP_COUNT) begin
                clamp_duty = `STEP_COUNT;
            end else begin
                clamp_duty = steps;
            end
        end
    endfunction

    reg [2:0]          state;
    reg [2:0]          next_state;
    reg [7:0]          hold_left;
    reg [7:0]          next_hold_left;
    reg [TENTH_W-1:0]  tenth_cnt;
    reg [8:0]          strength_steps;
    reg [PERIOD_W-1:0] period_cnt;
    reg [4:0]          step_div;
    reg [8:0]          step_idx;
    reg [8:0]          pending_duty;
    reg [8:0]          next_strength_steps;
    reg [TENTH_W-1:0]  next_tenth_cnt;
    reg [PERIOD_W-1:0] next_period_cnt;
    reg [4:0]          next_step_div;
    reg [8:0]          next_step_idx;
    reg [8:0]          next_shown;
    reg                next_pin;

    wire tenth_tick   = (tenth_cnt == TENTH_LAST);
    wire period_start = (period_cnt == PERIOD_LAST);
    wire step_tick    = (step_div == STEP_LAST);
    wire hold_last    = (hold_left <= 8'h01);

    assign indicator_active = (shown_duty_steps != 9'h000);

    // Hold setting
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strength_pulse_hold_time <= `HOLD_RESET; // R11
        end else if (hold_time_load) begin
            strength_pulse_hold_time <= hold_time_value; // R11
        end
    end

    // Pin function; unsupported code 3 is ignored
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            first_pulse_pin_function <= `FUNC_RESET; // R12
        end else if (pin_function_load && pin_function_value != 2'h3) begin
            first_pulse_pin_function <= pin_function_value; // R12
        end
    end

    // Latest packet strength in steps
    always @* begin
        next_strength_steps = strength_steps;
        if (packet_received) begin
            next_strength_steps = strength_to_steps(packet_strength_db); // R13
        end
    end

    // Strength register
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strength_steps <= 9'h000;
        end else begin
            strength_steps <= next_strength_steps;
        end
    end

    // Hold timer base: restarts on each packet
    always @* begin
        next_tenth_cnt = tenth_cnt + {{(TENTH_W-1){1'b0}}, 1'b1};
        if (packet_received || tenth_tick) begin
            next_tenth_cnt = {TENTH_W{1'b0}}; // R13
        end
    end

    // Hold timer base register
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tenth_cnt <= {TENTH_W{1'b0}};
        end else begin
            tenth_cnt <= next_tenth_cnt;
        end
    end

    // Display state; a packet wins over a same-cycle expiry
    always @* begin
        next_state     = state;
        next_hold_left = hold_left;
        if (packet_received) begin
            next_hold_left = strength_pulse_hold_time; // R13
            next_state     = state_on_packet(strength_pulse_hold_time);
        end else begin
            case (state)
                ST_DARK: begin
                    next_state = ST_DARK;
                end
                ST_HOLD: begin
                    if (tenth_tick) begin
                        if (hold_last) begin
                            next_hold_left = 8'h00;
                            next_state     = ST_DARK; // R8
                        end else begin
                            next_hold_left = hold_left - 8'h01; // R7
                        end
                    end
                end
                ST_STEADY: begin
                    next_state = ST_STEADY; // R10
                end
                default: begin
                    next_state = ST_DARK;
                end
            endcase
        end
    end

    // State register
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state     <= ST_DARK; // R9
            hold_left <= 8'h00;
        end else begin
            state     <= next_state;
            hold_left <= next_hold_left;
        end
    end

    // Duty wanted for the next period
    always @* begin
        case (first_pulse_pin_function)
            `FUNC_STRENGTH: begin
                if (state == ST_DARK) begin
                    pending_duty = 9'h000; // R4
                end else begin
                    pending_duty = strength_steps; // R3 R5 R6
                end
            end
            `FUNC_PASS: begin
                pending_duty = clamp_duty(passed_duty_steps); // R12
            end
            default: begin
                pending_duty = 9'h000;
            end
        endcase
    end

    // Next values of the period and step counters
    always @* begin
        next_period_cnt = period_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
        next_step_div   = step_div;
        next_step_idx   = step_idx;
        if (period_start) begin
            next_period_cnt = {PERIOD_W{1'b0}}; // R1
            next_step_div   = 5'h00;
            next_step_idx   = 9'h000;
        end else if (step_tick) begin
            next_step_div = 5'h00; // R2
            if (step_idx != STEP_TOP) begin
                next_step_idx = step_idx + 9'h001;
            end
        end else begin
            next_step_div = step_div + 5'h01;
        end
    end

    // Period and step counter registers
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            period_cnt <= {PERIOD_W{1'b0}};
            step_div   <= 5'h00;
            step_idx   <= 9'h000;
        end else begin
            period_cnt <= next_period_cnt;
            step_div   <= next_step_div;
            step_idx   <= next_step_idx;
        end
    end

    // Duty and pin level for the coming cycle
    always @* begin
        next_shown = shown_duty_steps;
        next_pin   = (step_idx < shown_duty_steps); // R2 R4
        if (period_start) begin
            next_shown = pending_duty; // R14
            next_pin   = (pending_duty != 9'h000); // R14
        end
    end

    // Duty latched at the period boundary only
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            shown_duty_steps <= 9'h000; // R9
        end else begin
            shown_duty_steps <= next_shown;
        end
    end

    // Pin: high while step index lies below the duty
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            first_pulse_output <= 1'b0;
        end else begin
            first_pulse_output <= next_pin;
        end
    end

endmodule // rssi_pwm_indicator

`default_nettype wire

// File: rssi_pwm_indicator_defines.vh
// Constants of the signal-strength pulse-width indicator
`ifndef RSSI_PWM_INDICATOR_DEFINES_VH
`define RSSI_PWM_INDICATOR_DEFINES_VH

// Clock rate in MHz
`define CLOCK_MHZ          125
// Total pulse period in ns (64 us)
`define PERIOD_NS          64000
// Smallest high-time increment in ns
`define STEP_NS            144
// Duty resolution in steps per period (445)
`define STEP_COUNT         9'h1bd
// Hold-time unit in ms
`define HOLD_UNIT_MS       100

// Hold-time setting: reset value (4 s) and the never-expire code
`define HOLD_RESET         8'h28
`define HOLD_FOREVER       8'hff
`define HOLD_NONE          8'h00

// First pin function select
`define FUNC_OFF           2'h0
`define FUNC_STRENGTH      2'h1
`define FUNC_PASS          2'h2
`define FUNC_RESET         2'h1

// Strength mapping: 24 % at sensitivity (107 steps)
`define DUTY_AT_SENS       24'sh00006b
// 1.7 % per dB = 7.566 steps, scaled by 256 (1937)
`define DUTY_SLOPE         24'sh000791
`define DUTY_SLOPE_SHIFT   8
// Floor for signals below sensitivity: 1 % (5 steps)
`define DUTY_MIN           24'sh000005
// Full scale (445 steps)
`define DUTY_FULL          24'sh0001bd

`endif

// File: tb.sv
// Self-checking bench of the signal-strength pulse-width indicator
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        pkt   = 1'b0;
    logic [7:0]  db    = 8'h00;
    logic        hl    = 1'b0;
    logic [7:0]  hv    = 8'h00;
    logic        fl    = 1'b0;
    logic [1:0]  fv    = 2'h0;
    logic [8:0]  pd    = 9'h000;
    wire         out;
    wire  [7:0]  hold;
    wire  [1:0]  func;
    wire  [8:0]  shown;
    wire         act;
    wire  [12:0] width;
    int          num_errors = 0;
    int          checked = 0;
    int          cyc = 0;
    always #4 clock = ~clock;
    rssi_pwm_indicator #(.TENTH_CYCLES(50)) dut (
        .clock(clock), .rst_b(rst_b), .packet_received(pkt),
        .packet_strength_db(db), .hold_time_load(hl), .hold_time_value(hv),
        .pin_function_load(fl), .pin_function_value(fv),
        .passed_duty_steps(pd), .first_pulse_output(out),
        .strength_pulse_hold_time(hold), .first_pulse_pin_function(func),
        .shown_duty_steps(shown), .indicator_active(act));
    pulse_meter meter (.clock(clock), .pin(out), .width(width));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic send(input logic [7:0] d);
        pkt = 1'b1;
        db = d;
        tick(1);
        pkt = 1'b0;
    endtask
    task automatic wait_shown(input logic [8:0] e);
        int n;
        for (n = 0; n < 8100 && shown !== e; n++) tick(1);
    endtask
    task automatic load_hold(input logic [7:0] v);
        hl = 1'b1;
        hv = v;
        tick(1);
        hl = 1'b0;
        chk({8'h00, hold}, {8'h00, v});
    endtask
    task automatic load_func(input logic [1:0] v, input logic [1:0] e);
        fl = 1'b1;
        fv = v;
        tick(1);
        fl = 1'b0;
        chk({14'h0000, func}, {14'h0000, e});
    endtask
    task automatic t_level(input logic [7:0] d, input logic [8:0] e);
        send(d);
        wait_shown(e);
        chk({7'h00, shown}, {7'h00, e});
        chk({15'h0000, act}, 16'h0001);
        $display("level test done");
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 100000) begin
            num_errors++;
            final_report;
        end
    end
    initial begin
        tick(10);
        rst_b = 1'b1;
        chk({8'h00, hold}, 16'h0028);
        chk({14'h0000, func}, 16'h0001);
        chk({7'h00, shown}, 16'h0000);
        chk({15'h0000, act}, 16'h0000);
        $display("reset test done");
        load_hold(8'hff);
        t_level(8'h0a, 9'h0b6);
        tick(8000);
        chk({3'h0, width / 13'd18}, 16'h00b6);
        t_level(8'h1e, 9'h14d);
        t_level(8'h9c, 9'h005);
        t_level(8'h3c, 9'h1bd);
        tick(8001);
        chk({7'h00, shown}, 16'h01bd);
        load_hold(8'hc8);
        t_level(8'h14, 9'h102);
        tick(10001);
        wait_shown(9'h000);
        chk({7'h00, shown}, 16'h0000);
        $display("hold test done");
        pd = 9'h100;
        load_func(2'h3, 2'h1);
        tick(1);
        load_func(2'h2, 2'h2);
        wait_shown(9'h100);
        chk({7'h00, shown}, 16'h0100);
        load_func(2'h0, 2'h0);
        $display("function test done");
        final_report;
    end
endmodule // tb
`default_nettype wire
